/* File: logic/ctm_core.sv */
// Notes on behaviour
// - With filter on, four agreeing input samples are needed before a new level passes.
// - Filter adds four system clock cycles of latency to the capture path.
// - Filter samples on the undivided system clock, unaffected by the prescaler.
// - Counter steps on local prescaler tick or the companion timer tick.
// - Eight modes: periodic, timeout, capture, frequency, pulse width, both, single, PWM8.
// - Debug halt stops counting and events unless the debug run bit is set.
// - Bottom is count zero; max is count all ones.
// - Top is highest count; update signalled at bottom or top by mode.
// - Reset leaves the timer in periodic interrupt mode.
// - Periodic mode flags an interrupt each time count becomes equal to top.
// - Count register readable at any time.
// - Periodic restarts at top; above top it runs to max, wraps and sets the overflow flag.
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
module ctm_core
	import ctm_pkg::*;
(
	// Clock and reset
	input  wire logic        CLK_IN,
	input  wire logic        ARST_N_IN,
	// AHB-Lite slave
	input  wire logic        HSEL_IN,
	input  wire logic [31:0] HADDR_IN,
	input  wire logic [1:0]  HTRANS_IN,
	input  wire logic        HWRITE_IN,
	input  wire logic [2:0]  HSIZE_IN,
	input  wire logic [31:0] HWDATA_IN,
	input  wire logic        HREADY_IN,
	output logic [31:0]      HRDATA_OUT,
	output logic             HREADYOUT_OUT,
	output logic             HRESP_OUT,
	// Event, debug and companion tick
	input  wire logic        EVENT_IN,
	input  wire logic        DEBUG_HALT_IN,
	input  wire logic        COMP_TICK_IN,
	// Interrupt and waveform
	output logic             IRQ_OUT,
	output logic             WAVE_OUT
);
	////////////////////////////////////////////////////////////////////////////////
	// Registers
	logic                    enable_q;
	logic [CTM_CLOCK_SELECT_FIELD_W-1:0] clock_select_field_q;
	ctm_mode_t               mode_q;
	logic                    outen_q;
	logic                    edge_q;
	logic                    filt_q;
	logic                    debug_run_bit_q;
	logic [CTM_FLAG_W-1:0]   mask_q;
	logic [CTM_FLAG_W-1:0]   flags_q;
	logic [CTM_CNT_W-1:0]    cnt_q;
	logic [CTM_CNT_W-1:0]    compare_capture_value_q;
	logic                    run_q;
	logic                    phase_q;
	logic                    div_q;
	logic                    lvl_q;
	logic                    wr_pend_q;
	logic                    rd_pend_q;
	logic [CTM_ADDR_W-1:0]   addr_q;

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode
	function automatic logic hit(input logic [CTM_ADDR_W-1:0] a,
	                             input logic [CTM_ADDR_W-1:0] off);
		hit = (a == off);
	endfunction : hit

	wire                  bus_go  = HSEL_IN && HREADY_IN && (HTRANS_IN == CTM_HTRANS_NONSEQ);
	wire [CTM_ADDR_W-1:0] a_addr  = HADDR_IN[CTM_ADDR_W-1:0];
	wire                  do_wr   = wr_pend_q;
	wire                  wr_ctla = do_wr && hit(addr_q, CTM_OFF_CONTROL_A_REGISTER);
	wire                  wr_ctlb = do_wr && hit(addr_q, CTM_OFF_CTRLB);
	wire                  wr_dbg  = do_wr && hit(addr_q, CTM_OFF_DBG);
	wire                  wr_mask = do_wr && hit(addr_q, CTM_OFF_MASK);
	wire                  wr_flg  = do_wr && hit(addr_q, CTM_OFF_FLAGS);
	wire                  wr_cnt  = do_wr && hit(addr_q, CTM_OFF_COUNT);
	wire                  wr_compare_capture_value = do_wr && hit(addr_q, CTM_OFF_COMPARE_CAPTURE_VALUE);
	wire                  rd_compare_capture_value = rd_pend_q && hit(addr_q, CTM_OFF_COMPARE_CAPTURE_VALUE);

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (a_addr)
			CTM_OFF_CONTROL_A_REGISTER: begin
				rd_mux[CTM_ENABLE_BIT] = enable_q;
				rd_mux[CTM_CLOCK_SELECT_FIELD_LSB +: CTM_CLOCK_SELECT_FIELD_W] = clock_select_field_q;
			end
			CTM_OFF_CTRLB: begin
				rd_mux[CTM_MODE_LSB +: CTM_MODE_W] = mode_q;
				rd_mux[CTM_OUTEN_BIT]  = outen_q;
				rd_mux[CTM_EDGE_BIT]   = edge_q;
				rd_mux[CTM_FILTER_BIT] = filt_q;
			end
			CTM_OFF_DBG:    rd_mux[CTM_DEBUG_RUN_BIT_BIT] = debug_run_bit_q;
			CTM_OFF_MASK:   rd_mux[CTM_FLAG_W-1:0] = mask_q;
			CTM_OFF_FLAGS:  rd_mux[CTM_FLAG_W-1:0] = flags_q;
			CTM_OFF_STATUS: rd_mux[CTM_RUN_BIT] = run_q;
			CTM_OFF_COUNT:  rd_mux[CTM_CNT_W-1:0] = cnt_q;
			CTM_OFF_COMPARE_CAPTURE_VALUE:   rd_mux[CTM_CNT_W-1:0] = compare_capture_value_q;
			default:        rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			wr_pend_q     <= 1'b0;
			rd_pend_q     <= 1'b0;
			addr_q        <= '0;
			HRDATA_OUT    <= 32'h0000_0000;
			HREADYOUT_OUT <= 1'b0;
			HRESP_OUT     <= 1'b0;
		end else begin
			// Zero wait states; always OKAY
			HREADYOUT_OUT <= 1'b1;
			HRESP_OUT     <= 1'b0;
			wr_pend_q     <= bus_go && HWRITE_IN;
			rd_pend_q     <= bus_go && !HWRITE_IN;
			if (bus_go) begin
				addr_q <= a_addr;
			end
			if (bus_go && !HWRITE_IN) begin
				HRDATA_OUT <= rd_mux;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control registers
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			enable_q <= 1'b0;
			clock_select_field_q <= CTM_CLK_DIV1;
			mode_q   <= CTM_MODE_PERIODIC;
			outen_q  <= 1'b0;
			edge_q   <= 1'b0;
			filt_q   <= 1'b0;
			debug_run_bit_q <= 1'b0;
			mask_q   <= '0;
		end else begin
			if (wr_ctla) begin
				enable_q <= HWDATA_IN[CTM_ENABLE_BIT];
				clock_select_field_q <= HWDATA_IN[CTM_CLOCK_SELECT_FIELD_LSB +: CTM_CLOCK_SELECT_FIELD_W];
			end
			if (wr_ctlb) begin
				mode_q  <= ctm_mode_t'(HWDATA_IN[CTM_MODE_LSB +: CTM_MODE_W]);
				outen_q <= HWDATA_IN[CTM_OUTEN_BIT];
				edge_q  <= HWDATA_IN[CTM_EDGE_BIT];
				filt_q  <= HWDATA_IN[CTM_FILTER_BIT];
			end
			if (wr_dbg) begin
				debug_run_bit_q <= HWDATA_IN[CTM_DEBUG_RUN_BIT_BIT];
			end
			if (wr_mask) begin
				mask_q <= HWDATA_IN[CTM_FLAG_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Event input path
	logic ev_lvl;

	// Event router is logic on this clock, so no synchroniser
	ctm_filter #(
		.LEN (CTM_FILT_LEN)
	) u_filter (
		.clk_in    (CLK_IN),
		.arst_n_in (ARST_N_IN),
		.enable_in (filt_q),
		.sample_in (EVENT_IN),
		.level_out (ev_lvl)
	);

	// Halted peripheral ignores events and stops counting
	wire active  = enable_q && (!DEBUG_HALT_IN || debug_run_bit_q);
	wire ev_rise = ev_lvl && !lvl_q;
	wire ev_fall = !ev_lvl && lvl_q;
	// Edge bit picks the falling edge as the capture edge
	wire ev_edge = active && (edge_q ? ev_fall : ev_rise);
	wire ev_any  = active && (ev_rise || ev_fall);

	////////////////////////////////////////////////////////////////////////////////
	// Count clock
	wire tick_local = (clock_select_field_q == CTM_CLK_DIV1) || ((clock_select_field_q == CTM_CLK_DIV2) && div_q);
	wire tick_comp  = (clock_select_field_q == CTM_CLK_COMP) && COMP_TICK_IN;
	wire tick       = active && (tick_local || tick_comp);

	////////////////////////////////////////////////////////////////////////////////
	// Counter terms
	wire [CTM_CNT_W-1:0] cnt_inc  = cnt_q + 16'h0001;
	wire                 at_max   = (cnt_q == CTM_CNT_MAX);
	wire                 at_top   = (cnt_q == compare_capture_value_q);
	wire                 to_top   = (cnt_inc == compare_capture_value_q);
	wire [7:0]           pwm_per  = compare_capture_value_q[7:0];
	wire [7:0]           pwm_high = compare_capture_value_q[15:8];
	wire                 pwm_end  = (cnt_q[7:0] == pwm_per);

	logic [CTM_CNT_W-1:0] cnt_d;
	logic [CTM_CNT_W-1:0] compare_capture_value_d;
	logic                 run_d;
	logic                 phase_d;
	logic                 wave_d;
	logic [CTM_FLAG_W-1:0] ev_set;

	always_comb begin
		cnt_d   = cnt_q;
		compare_capture_value_d  = compare_capture_value_q;
		run_d   = run_q;
		phase_d = phase_q;
		wave_d  = 1'b0;
		ev_set  = '0;
		case (mode_q)
			CTM_MODE_PERIODIC: begin
				if (tick) begin
					// Past top the count runs to max, wraps and sets the overflow flag
					cnt_d = at_top ? CTM_CNT_ZERO : cnt_inc;
					ev_set[CTM_FLAG_CAPT] = to_top;
					ev_set[CTM_FLAG_OVF]  = at_max && !at_top;
				end
			end
			CTM_MODE_TIMEOUT: begin
				if (tick) begin
					cnt_d = cnt_inc;
					ev_set[CTM_FLAG_CAPT] = run_q && to_top;
					ev_set[CTM_FLAG_OVF]  = at_max;
				end
				if (ev_edge) begin
					run_d = !run_q;
					if (!run_q) begin
						cnt_d = CTM_CNT_ZERO;
					end
				end
			end
			CTM_MODE_CAPTURE, CTM_MODE_FREQ: begin
				if (tick) begin
					cnt_d = cnt_inc;
					ev_set[CTM_FLAG_OVF] = at_max;
				end
				if (ev_edge) begin
					compare_capture_value_d = cnt_q;
					ev_set[CTM_FLAG_CAPT] = 1'b1;
					if (mode_q == CTM_MODE_FREQ) begin
						cnt_d = CTM_CNT_ZERO;
					end
				end
			end
			CTM_MODE_PWIDTH: begin
				if (tick) begin
					cnt_d = cnt_inc;
					ev_set[CTM_FLAG_OVF] = at_max;
				end
				if (active && ev_rise) begin
					cnt_d = CTM_CNT_ZERO;
				end else if (active && ev_fall) begin
					compare_capture_value_d = cnt_q;
					ev_set[CTM_FLAG_CAPT] = 1'b1;
				end
			end
			CTM_MODE_FRQPW: begin
				if (tick && run_q) begin
					cnt_d = cnt_inc;
					ev_set[CTM_FLAG_OVF] = at_max;
				end
				// A new sequence waits until the flag is cleared
				if (!flags_q[CTM_FLAG_CAPT] && active) begin
					if (ev_rise && !run_q) begin
						cnt_d   = CTM_CNT_ZERO;
						run_d   = 1'b1;
						phase_d = 1'b0;
					end else if (ev_fall && run_q && !phase_q) begin
						compare_capture_value_d  = cnt_q;
						phase_d = 1'b1;
					end else if (ev_rise && run_q && phase_q) begin
						run_d   = 1'b0;
						ev_set[CTM_FLAG_CAPT] = 1'b1;
					end
				end
			end
			CTM_MODE_SINGLE: begin
				if (run_q && tick) begin
					if (at_top) begin
						run_d = 1'b0;
						ev_set[CTM_FLAG_CAPT] = 1'b1;
					end else begin
						cnt_d = cnt_inc;
					end
				end else if (!run_q && (edge_q ? ev_any : ev_rise && active)) begin
					cnt_d = CTM_CNT_ZERO;
					run_d = 1'b1;
				end
				wave_d = run_d;
			end
			CTM_MODE_PWM8: begin
				if (tick) begin
					// Update at bottom: the period restarts after the low byte
					cnt_d = pwm_end ? CTM_CNT_ZERO : {8'h00, cnt_q[7:0] + 8'h01};
					ev_set[CTM_FLAG_CAPT] = pwm_end;
				end
				wave_d = enable_q && (pwm_per != 8'h00) && (cnt_d[7:0] < pwm_high);
			end
			default: begin
				cnt_d = cnt_q;
			end
		endcase
		// Software writes win over the counter's own update
		if (wr_cnt) begin
			cnt_d = HWDATA_IN[CTM_CNT_W-1:0];
		end
		if (wr_compare_capture_value) begin
			compare_capture_value_d = HWDATA_IN[CTM_CNT_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Flags: hardware set beats a write-one clear
	wire auto_clr = rd_compare_capture_value && (mode_q inside {CTM_MODE_CAPTURE, CTM_MODE_FREQ,
	                                           CTM_MODE_PWIDTH, CTM_MODE_FRQPW});
	logic [CTM_FLAG_W-1:0] clr_mask;
	logic [CTM_FLAG_W-1:0] flags_d;
	assign clr_mask = (wr_flg ? HWDATA_IN[CTM_FLAG_W-1:0] : '0)
	                | {{(CTM_FLAG_W-1){1'b0}}, auto_clr};
	assign flags_d  = (flags_q & ~clr_mask) | ev_set;

	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			cnt_q    <= CTM_CNT_ZERO;
			compare_capture_value_q   <= CTM_COMPARE_CAPTURE_VALUE_RST;
			run_q    <= 1'b0;
			phase_q  <= 1'b0;
			div_q    <= 1'b0;
			lvl_q    <= 1'b0;
			flags_q  <= '0;
			IRQ_OUT  <= 1'b0;
			WAVE_OUT <= 1'b0;
		end else begin
			cnt_q    <= cnt_d;
			compare_capture_value_q   <= compare_capture_value_d;
			run_q    <= enable_q ? run_d : 1'b0;
			phase_q  <= phase_d;
			div_q    <= active ? !div_q : div_q;
			lvl_q    <= ev_lvl;
			flags_q  <= flags_d;
			IRQ_OUT  <= |(flags_d & mask_q);
			WAVE_OUT <= outen_q && wave_d;
		end
	end
endmodule : ctm_core

/* File: logic/ctm_filter.sv */
module ctm_filter
	import ctm_pkg::*;
#(
	parameter int LEN = CTM_FILT_LEN
) (
	input  wire logic clk_in,
	input  wire logic arst_n_in,
	input  wire logic enable_in,
	input  wire logic sample_in,
	output logic      level_out
);
	logic [LEN-1:0] hist_q;
	wire            all_hi = &hist_q;
	wire            all_lo = ~|hist_q;

	// Runs on the undivided clock; prescaler never gates it
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			hist_q    <= '0;
			level_out <= 1'b0;
		end else begin
			hist_q <= {hist_q[LEN-2:0], sample_in};
			if (!enable_in) begin
				level_out <= sample_in;
			end else if (all_hi || all_lo) begin
				level_out <= hist_q[LEN-1];
			end
		end
	end
endmodule : ctm_filter

/* File: logic/ctm_pkg.sv */
package ctm_pkg;
	// Register byte offsets
	localparam logic [7:0] CTM_OFF_CONTROL_A_REGISTER  = 8'h00;
	localparam logic [7:0] CTM_OFF_CTRLB  = 8'h04;
	localparam logic [7:0] CTM_OFF_DBG    = 8'h08;
	localparam logic [7:0] CTM_OFF_MASK   = 8'h0C;
	localparam logic [7:0] CTM_OFF_FLAGS  = 8'h10;
	localparam logic [7:0] CTM_OFF_STATUS = 8'h14;
	localparam logic [7:0] CTM_OFF_COUNT  = 8'h18;
	localparam logic [7:0] CTM_OFF_COMPARE_CAPTURE_VALUE   = 8'h1C;
	localparam int         CTM_ADDR_W     = 8;

	// Control A fields
	localparam int CTM_ENABLE_BIT = 0;
	localparam int CTM_CLOCK_SELECT_FIELD_LSB = 1;
	localparam int CTM_CLOCK_SELECT_FIELD_W   = 2;
	// Control B fields
	localparam int CTM_MODE_LSB   = 0;
	localparam int CTM_MODE_W     = 3;
	localparam int CTM_OUTEN_BIT  = 4;
	localparam int CTM_EDGE_BIT   = 5;
	localparam int CTM_FILTER_BIT = 6;
	// Debug control fields
	localparam int CTM_DEBUG_RUN_BIT_BIT = 0;
	// Flag and mask layout
	localparam int CTM_FLAG_W     = 2;
	localparam int CTM_FLAG_CAPT  = 0;
	localparam int CTM_FLAG_OVF   = 1;
	// Status fields
	localparam int CTM_RUN_BIT    = 0;

	localparam int          CTM_CNT_W     = 16;
	localparam logic [15:0] CTM_CNT_ZERO  = 16'h0000;
	localparam logic [15:0] CTM_CNT_MAX   = 16'hFFFF;
	localparam logic [15:0] CTM_COMPARE_CAPTURE_VALUE_RST  = 16'h0000;
	localparam int          CTM_FILT_LEN  = 4;

	// Clock select codes
	localparam logic [1:0] CTM_CLK_DIV1 = 2'h0;
	localparam logic [1:0] CTM_CLK_DIV2 = 2'h1;
	localparam logic [1:0] CTM_CLK_COMP = 2'h2;

	// AHB codes
	localparam logic [1:0] CTM_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] CTM_HSIZE_WORD    = 3'h2;

	typedef enum logic [2:0] {
		CTM_MODE_PERIODIC = 3'b000,
		CTM_MODE_TIMEOUT  = 3'b001,
		CTM_MODE_CAPTURE  = 3'b010,
		CTM_MODE_FREQ     = 3'b011,
		CTM_MODE_PWIDTH   = 3'b100,
		CTM_MODE_FRQPW    = 3'b101,
		CTM_MODE_SINGLE   = 3'b110,
		CTM_MODE_PWM8     = 3'b111
	} ctm_mode_t;
endpackage : ctm_pkg

/* File: tb/ctm_core_monitor.sv */
module ctm_core_monitor
	import ctm_pkg::*;
(
	// Clock and reset
	input wire logic        CLK_IN,
	input wire logic        ARST_N_IN,
	// Bus
	input wire logic        HSEL_IN,
	input wire logic [31:0] HADDR_IN,
	input wire logic [1:0]  HTRANS_IN,
	input wire logic        HWRITE_IN,
	input wire logic [31:0] HWDATA_IN,
	input wire logic        HREADY_IN,
	input wire logic [31:0] HRDATA_OUT,
	input wire logic        HREADYOUT_OUT,
	input wire logic        HRESP_OUT,
	// Outputs
	input wire logic        IRQ_OUT,
	input wire logic        WAVE_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	logic                  rd_take, wr_take, any_take, wr_p_q;
	logic [7:0]            wr_a_q, ctrlb_q;
	logic [CTM_FLAG_W-1:0] mask_q;

	assign any_take = HSEL_IN && HREADY_IN && HTRANS_IN == CTM_HTRANS_NONSEQ;
	assign rd_take  = any_take && !HWRITE_IN;
	assign wr_take  = any_take && HWRITE_IN;

	// Shadow of mask and control B, updated in the write data phase
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			wr_p_q  <= 1'b0;
			wr_a_q  <= 8'h00;
			mask_q  <= '0;
			ctrlb_q <= 8'h00;
		end else begin
			wr_p_q <= wr_take;
			wr_a_q <= HADDR_IN[7:0];
			if (wr_p_q && wr_a_q == CTM_OFF_MASK) mask_q <= HWDATA_IN[CTM_FLAG_W-1:0];
			if (wr_p_q && wr_a_q == CTM_OFF_CTRLB) ctrlb_q <= HWDATA_IN[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!ARST_N_IN);

	sequence unmapped_rd_s;
		rd_take && HADDR_IN[7:0] > CTM_OFF_COMPARE_CAPTURE_VALUE;
	endsequence

	hresp_okay_a: assert property (HRESP_OUT == 1'b0) else $error("bad hresp");
	hready_up_a: assert property ($past(ARST_N_IN) |-> HREADYOUT_OUT) else $error("wait state");
	rdata_upper_a: assert property (HRDATA_OUT[31:16] == 16'h0000)
		else $error("upper read bits set");
	rdata_hold_a: assert property ($changed(HRDATA_OUT) |-> $past(rd_take))
		else $error("read data moved");
	unmapped_zero_a: assert property (unmapped_rd_s |=> HRDATA_OUT == 32'h00000000)
		else $error("unmapped read not zero");
	irq_mask_a: assert property (IRQ_OUT |-> $past(mask_q) != '0)
		else $error("irq while masked");
	irq_sticky_a: assert property ($fell(IRQ_OUT) |-> $past(any_take, 2) ||
		$past(any_take, 3) || $past(any_take, 4)) else $error("irq dropped alone");
	wave_mode_a: assert property (!(ctrlb_q[CTM_OUTEN_BIT] && ctrlb_q[2:1] == 2'h3)
		|=> !WAVE_OUT) else $error("wave outside its modes");
endmodule : ctm_core_monitor

bind ctm_core ctm_core_monitor u_mon (.CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN), .HSEL_IN(HSEL_IN),
	.HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HWDATA_IN(HWDATA_IN),
	.HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT), .HREADYOUT_OUT(HREADYOUT_OUT),
	.HRESP_OUT(HRESP_OUT), .IRQ_OUT(IRQ_OUT), .WAVE_OUT(WAVE_OUT));

/* File: tb/ctm_evt_model.sv */
module ctm_evt_model (
	// Clock and control
	input  wire logic clk_in,
	input  wire logic tick_en_in,
	// Event and companion tick
	output logic      event_out,
	output logic      tick_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] div_q     = 2'h0;
	initial event_out = 1'b0;
	initial tick_out  = 1'b0;

	// Companion tick every fourth clock, stops when not enabled
	always @(posedge clk_in) begin
		div_q    <= div_q + 2'h1;
		tick_out <= tick_en_in && div_q == 2'h3;
	end

	task automatic pulse(input int len);
		@(posedge clk_in);
		event_out <= 1'b1;
		repeat (len) @(posedge clk_in);
		event_out <= 1'b0;
	endtask : pulse
endmodule : ctm_evt_model

/* File: tb/tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ctm_pkg::*;
	logic        clk, arst_n, hsel, hwrite, halt, tick_en, irq, wave, hready, hresp, evt, tick;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, v0, v1;
	int          n_mismatch, n_tests;

	ctm_evt_model u_evt (.clk_in(clk), .tick_en_in(tick_en), .event_out(evt), .tick_out(tick));
	ctm_core DUT (.CLK_IN(clk), .ARST_N_IN(arst_n), .HSEL_IN(hsel), .HADDR_IN(haddr),
		.HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(CTM_HSIZE_WORD), .HWDATA_IN(hwdata),
		.HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
		.EVENT_IN(evt), .DEBUG_HALT_IN(halt), .COMP_TICK_IN(tick), .IRQ_OUT(irq),
		.WAVE_OUT(wave));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic summarize;
		$display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Entered just after a rising edge; returns at the edge that ends the data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		n = 0;
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= CTM_HTRANS_NONSEQ;
		hwrite <= w;
		do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 100);
		rd = hrdata;
		if (n >= 100) begin
			n_mismatch++;
			summarize();
		end
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, v0);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000, v1);
		chk(v1, exp);
	endtask : rdc

	task automatic wait_irq(input logic lvl, input int max);
		int n;
		n = 0;
		while (irq !== lvl && n < max) begin @(posedge clk); n++; end
		chk({31'h0, irq}, {31'h0, lvl});
		// A missed level is a hang, so end the run here
		if (irq !== lvl) begin
			summarize();
		end
	endtask : wait_irq

	// Counter advance between two reads spaced gap+2 cycles apart
	task automatic pair(input logic [31:0] control_a_register, input int gap, input logic [31:0] diff);
		wr(CTM_OFF_CONTROL_A_REGISTER, control_a_register);
		bus(1'b0, CTM_OFF_COUNT, 32'h00000000, v0);
		repeat (gap) @(posedge clk);
		bus(1'b0, CTM_OFF_COUNT, 32'h00000000, v1);
		chk(v1 - v0, diff);
	endtask : pair

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rdc(CTM_OFF_CONTROL_A_REGISTER, 32'h00000000);
		rdc(CTM_OFF_CTRLB, 32'h00000000);
		rdc(CTM_OFF_COUNT, 32'h00000000);
		rdc(CTM_OFF_COMPARE_CAPTURE_VALUE, 32'h00000000);
		rdc(CTM_OFF_FLAGS, 32'h00000000);
		rdc(8'h40, 32'h00000000);
		for (int m = 0; m < 8; m++) begin
			wr(CTM_OFF_CTRLB, m);
			rdc(CTM_OFF_CTRLB, m);
		end
		wr(CTM_OFF_CTRLB, 32'h00000000);
	endtask : t_reset

	task automatic t_periodic;
		wr(CTM_OFF_COMPARE_CAPTURE_VALUE, 32'h00000005);
		wr(CTM_OFF_MASK, 32'h00000001);
		wr(CTM_OFF_CONTROL_A_REGISTER, 32'h00000001);
		wait_irq(1'b1, 20);
		rdc(CTM_OFF_FLAGS, 32'h00000001);
		bus(1'b0, CTM_OFF_COUNT, 32'h00000000, v0);
		chk({31'h0, v0 <= 32'h5}, 32'h00000001);
		wr(CTM_OFF_MASK, 32'h00000000);
		wait_irq(1'b0, 4);
		rdc(CTM_OFF_FLAGS, 32'h00000001);
		wr(CTM_OFF_MASK, 32'h00000001);
		wait_irq(1'b1, 4);
		wr(CTM_OFF_CONTROL_A_REGISTER, 32'h00000000);
		wr(CTM_OFF_FLAGS, 32'h00000001);
		wait_irq(1'b0, 4);
		rdc(CTM_OFF_FLAGS, 32'h00000000);
	endtask : t_periodic

	task automatic t_lower;
		wr(CTM_OFF_COUNT, 32'h00000010);
		wr(CTM_OFF_COMPARE_CAPTURE_VALUE, 32'h00000003);
		wr(CTM_OFF_FLAGS, 32'h00000003);
		wr(CTM_OFF_CONTROL_A_REGISTER, 32'h00000001);
		repeat (20) @(posedge clk);
		rdc(CTM_OFF_FLAGS, 32'h00000000);
		wr(CTM_OFF_COUNT, 32'h0000FFF8);
		repeat (20) @(posedge clk);
		rdc(CTM_OFF_FLAGS, 32'h00000003);
		wr(CTM_OFF_CONTROL_A_REGISTER, 32'h00000000);
	endtask : t_lower

	task automatic t_rate;
		wr(CTM_OFF_COMPARE_CAPTURE_VALUE, 32'h0000FFFF);
		pair(32'h00000001, 0, 32'h00000002);
		pair(32'h00000003, 0, 32'h00000001);
		halt <= 1'b1;
		pair(32'h00000001, 0, 32'h00000000);
		wr(CTM_OFF_DBG, 32'h00000001);
		pair(32'h00000001, 0, 32'h00000002);
		halt <= 1'b0;
		pair(32'h00000007, 0, 32'h00000000);
		pair(32'h00000005, 0, 32'h00000000);
		tick_en <= 1'b1;
		pair(32'h00000005, 38, 32'h0000000A);
		wr(CTM_OFF_CONTROL_A_REGISTER, 32'h00000000);
	endtask : t_rate

	task automatic t_capture;
		wr(CTM_OFF_COUNT, 32'h00000000);
		wr(CTM_OFF_CTRLB, 32'h00000042);
		wr(CTM_OFF_FLAGS, 32'h00000003);
		wr(CTM_OFF_CONTROL_A_REGISTER, 32'h00000003);
		u_evt.pulse(3);
		repeat (12) @(posedge clk);
		rdc(CTM_OFF_FLAGS, 32'h00000000);
		u_evt.pulse(6);
		repeat (12) @(posedge clk);
		rdc(CTM_OFF_FLAGS, 32'h00000001);
		bus(1'b0, CTM_OFF_COMPARE_CAPTURE_VALUE, 32'h00000000, v0);
		rdc(CTM_OFF_FLAGS, 32'h00000000);
	endtask : t_capture

	task automatic t_wave;
		int hi;
		hi = 0;
		wr(CTM_OFF_CONTROL_A_REGISTER, 32'h00000000);
		wr(CTM_OFF_CTRLB, 32'h00000017);
		wr(CTM_OFF_COMPARE_CAPTURE_VALUE, 32'h00000307);
		wr(CTM_OFF_COUNT, 32'h00000000);
		wr(CTM_OFF_FLAGS, 32'h00000003);
		wr(CTM_OFF_CONTROL_A_REGISTER, 32'h00000001);
		repeat (4) @(posedge clk);
		// Two whole periods of eight, three high cycles in each
		repeat (16) begin
			@(posedge clk);
			if (wave === 1'b1) hi++;
		end
		chk(hi, 32'h00000006);
		rdc(CTM_OFF_FLAGS, 32'h00000001);
		wr(CTM_OFF_CONTROL_A_REGISTER, 32'h00000000);
		wr(CTM_OFF_CTRLB, 32'h00000016);
		wr(CTM_OFF_COMPARE_CAPTURE_VALUE, 32'h00000005);
		wr(CTM_OFF_FLAGS, 32'h00000003);
		wr(CTM_OFF_CONTROL_A_REGISTER, 32'h00000001);
		hi = 0;
		// Shot runs from zero to top inclusive
		fork
			u_evt.pulse(3);
			repeat (20) begin
				@(posedge clk);
				if (wave === 1'b1) hi++;
			end
		join
		chk(hi, 32'h00000006);
		rdc(CTM_OFF_FLAGS, 32'h00000001);
		wr(CTM_OFF_CONTROL_A_REGISTER, 32'h00000000);
	endtask : t_wave

	initial begin
		arst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h00000000;
		halt = 1'b0;
		tick_en = 1'b0;
		n_mismatch = 0;
		n_tests = 0;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_periodic();
		t_lower();
		t_rate();
		t_capture();
		t_wave();
		summarize();
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		summarize();
	end
endmodule : tb
